// >>> hdl/pmcr_map.svh
/*
  Offsets, field positions, reset values and the data-scale codes of the
  power-management configuration slice.
  Assumes inclusion by its bare name from the package and the design files.
*/
`ifndef PMCR_MAP_SVH
`define PMCR_MAP_SVH

// ----------------------------------------------------------------------------
// Configuration-header byte offsets
// ----------------------------------------------------------------------------
`define PMCR_OFS_REVISION      8'h08
`define PMCR_OFS_SUBSYSTEM     8'h2E
`define PMCR_OFS_POWER_MGMT    8'h54

// ----------------------------------------------------------------------------
// Field positions in power_mgmt_control
// ----------------------------------------------------------------------------
`define PMCR_STATE_LSB         0
`define PMCR_STATE_MSB         1
`define PMCR_WAKE_EN_BIT       8
`define PMCR_SEL_LSB           9
`define PMCR_SEL_MSB           12
`define PMCR_SCALE_LSB         13
`define PMCR_SCALE_MSB         14
`define PMCR_FLAG_BIT          15

// ----------------------------------------------------------------------------
// Reset values and scale codes
// ----------------------------------------------------------------------------
`define PMCR_PM_RESET          16'h0000
`define PMCR_SUBSYS_RESET      16'h0000
`define PMCR_SCALE_UNKNOWN     2'h0
`define PMCR_SCALE_TENTH       2'h1
`define PMCR_SCALE_HUNDREDTH   2'h2
// Word index of the configuration parameter word in the serial ROM
`define PMCR_EE_PARAM_WORD     2'h0
`define PMCR_EE_SUBSYS_WORD    2'h3
// Bit of the parameter word carrying the wake-report enable
`define PMCR_EE_WAKE_EN_BIT    8

`endif

// >>> hdl/pmcr_pkg.sv
/*
  Types of the power-management configuration slice.
  Assumes pmcr_map.svh is on the include path.
*/
`include "pmcr_map.svh"

package pmcr_pkg;

  // Power states held in the power_state_field
  typedef enum logic [1:0] {
    PMCR_D0 = 2'b00,
    PMCR_D1 = 2'b01,
    PMCR_D2 = 2'b10,
    PMCR_D3 = 2'b11
  } pmcr_pstate_t;

  // Initialisation sequencer of the register bank
  typedef enum logic [1:0] {
    PMCR_S_WAIT  = 2'b00,
    PMCR_S_READY = 2'b01
  } pmcr_init_t;

  // Scale lookup decoder state
  typedef struct packed {
    logic [1:0] scale;
  } pmcr_scale_state_t;

  // Whole register-bank state
  typedef struct packed {
    pmcr_init_t   init;
    pmcr_pstate_t pstate;
    logic         wake_en;
    logic [3:0]   data_sel;
    logic         wake_flag;
    logic [15:0]  subsys;
    logic [15:0]  rdata;
    logic         rvalid;
    logic         wake_out;
  } pmcr_state_t;

endpackage

// >>> hdl/pmcr_scale.sv
/*
  Data-scale lookup: maps the data-select field to the scale code that the
  data-scale field reports. The scale code is registered.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none

`include "pmcr_map.svh"

module pmcr_scale
  import pmcr_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [3:0] sel_i,
  output var  logic [1:0] scale_o
);

  pmcr_scale_state_t state_reg;
  pmcr_scale_state_t state_next;

  // ----------------------------------------------------------------------------
  // Lookup
  // ----------------------------------------------------------------------------
  // Selections 0..7 are power figures in tenths, 8 is a hundredths figure,
  // the rest carry no data so their scale is unknown
  always_comb begin
    state_next = state_reg;
    if (sel_i < 4'h8) begin
      state_next.scale = `PMCR_SCALE_TENTH;
    end else if (sel_i == 4'h8) begin
      state_next.scale = `PMCR_SCALE_HUNDREDTH;
    end else begin
      state_next.scale = `PMCR_SCALE_UNKNOWN;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign scale_o = state_reg.scale;

endmodule

`default_nettype wire

// >>> hdl/pmcr_regs.sv
/*
  Power-management slice of a network controller's PCI configuration header:
  power_mgmt_control, revision_code and subsystem_code.
  Assumes a configuration-cycle front end on the same clock that gives a
  one-cycle read or write strobe with byte offset and byte enables, a serial
  ROM loader that presents words with an index and a valid pulse, and a
  done pulse when auto initialisation ends. WAKE_EVENT_I comes from logic
  on the same clock (the wake-criteria decoder).
*/
`timescale 1ns/10ps
`default_nettype none

`include "pmcr_map.svh"

module pmcr_regs
  import pmcr_pkg::*;
#(
  parameter logic [7:0] REVISION = 8'h5A   // Arbitrary value, set per silicon revision
)(
  input  wire logic        REF_CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic        CFG_RD_I,
  input  wire logic        CFG_WR_I,
  input  wire logic [7:0]  CFG_ADDR_I,
  input  wire logic [1:0]  CFG_BE_I,
  input  wire logic [15:0] CFG_WDATA_I,
  output var  logic [15:0] CFG_RDATA_O,
  output var  logic        CFG_RVALID_O,
  input  wire logic        EE_WORD_VALID_I,
  input  wire logic [1:0]  EE_WORD_INDEX_I,
  input  wire logic [15:0] EE_WORD_I,
  input  wire logic        EE_DONE_I,
  input  wire logic        WAKE_EVENT_I,
  output var  logic        WAKE_O,
  output var  logic        TARGET_EN_O,
  output var  logic        MASTER_EN_O,
  output var  logic [1:0]  POWER_STATE_O,
  output var  logic [3:0]  DATA_SEL_O
);

  pmcr_state_t state_reg;
  pmcr_state_t state_next;
  logic [1:0]  scale;
  logic [15:0] pm_word;

  // ----------------------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------------------
  // Word offsets are matched ignoring bit 0 so byte accesses at +1 still hit
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr[7:1] == ofs[7:1]);
  endfunction

  pmcr_scale u_scale (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RSTN_I),
    .sel_i   (state_reg.data_sel),
    .scale_o (scale)
  );

  // Reserved bits 7:2 always read zero
  always_comb begin
    pm_word = 16'h0000;
    pm_word[`PMCR_STATE_MSB:`PMCR_STATE_LSB] = state_reg.pstate;
    pm_word[`PMCR_WAKE_EN_BIT] = state_reg.wake_en;
    pm_word[`PMCR_SEL_MSB:`PMCR_SEL_LSB] = state_reg.data_sel;
    pm_word[`PMCR_SCALE_MSB:`PMCR_SCALE_LSB] = scale;
    pm_word[`PMCR_FLAG_BIT] = state_reg.wake_flag;
  end

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.rvalid = 1'b0;
    // Loader words only matter before initialisation completes
    case (state_reg.init)
      PMCR_S_WAIT: begin
        if (EE_WORD_VALID_I && EE_WORD_INDEX_I == `PMCR_EE_PARAM_WORD) begin
          state_next.wake_en = EE_WORD_I[`PMCR_EE_WAKE_EN_BIT];
        end
        if (EE_WORD_VALID_I && EE_WORD_INDEX_I == `PMCR_EE_SUBSYS_WORD) begin
          state_next.subsys = EE_WORD_I;
        end
        if (EE_DONE_I) begin
          state_next.init = PMCR_S_READY;
        end
      end
      PMCR_S_READY: begin
        state_next.init = PMCR_S_READY;
      end
      default: begin
        state_next.init = PMCR_S_WAIT;
      end
    endcase
    // Host writes; read-only registers ignore them
    if (CFG_WR_I && hit(CFG_ADDR_I, `PMCR_OFS_POWER_MGMT)) begin
      if (CFG_BE_I[0]) begin
        state_next.pstate = pmcr_pstate_t'(CFG_WDATA_I[`PMCR_STATE_MSB:`PMCR_STATE_LSB]);
      end
      if (CFG_BE_I[1]) begin
        state_next.wake_en = CFG_WDATA_I[`PMCR_WAKE_EN_BIT];
        state_next.data_sel = CFG_WDATA_I[`PMCR_SEL_MSB:`PMCR_SEL_LSB];
        if (CFG_WDATA_I[`PMCR_FLAG_BIT]) begin
          state_next.wake_flag = 1'b0;
        end
      end
    end
    // Set placed after clear so a coincident event is kept
    if (WAKE_EVENT_I) begin
      state_next.wake_flag = 1'b1;
    end
    state_next.wake_out = WAKE_EVENT_I && state_next.wake_en;
    // Reads answer one cycle later; unmapped offsets return zero
    if (CFG_RD_I) begin
      state_next.rvalid = 1'b1;
      if (hit(CFG_ADDR_I, `PMCR_OFS_POWER_MGMT)) begin
        state_next.rdata = pm_word;
      end else if (CFG_ADDR_I == `PMCR_OFS_REVISION) begin
        state_next.rdata = {8'h00, REVISION};
      end else if (hit(CFG_ADDR_I, `PMCR_OFS_SUBSYSTEM)) begin
        state_next.rdata = state_reg.subsys;
      end else begin
        state_next.rdata = 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Enables are gated straight from the stored state, no extra latency
  assign TARGET_EN_O   = (state_reg.pstate == PMCR_D0);
  assign MASTER_EN_O   = (state_reg.pstate == PMCR_D0);
  assign POWER_STATE_O = state_reg.pstate;
  assign DATA_SEL_O    = state_reg.data_sel;
  assign CFG_RDATA_O   = state_reg.rdata;
  assign CFG_RVALID_O  = state_reg.rvalid;
  assign WAKE_O        = state_reg.wake_out;

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);

  state_write_a: assert property (CFG_WR_I && CFG_BE_I[0] && hit(CFG_ADDR_I, 8'h54)
    |=> POWER_STATE_O == $past(CFG_WDATA_I[1:0])) else $error("power state not written");
  gate_off_a: assert property (POWER_STATE_O != 2'b00 |-> !TARGET_EN_O && !MASTER_EN_O)
    else $error("cycles enabled outside D0");
  wake_gate_a: assert property (WAKE_O |-> $past(WAKE_EVENT_I) && state_reg.wake_en)
    else $error("wake output without enable");
  wake_load_a: assert property (state_reg.init == PMCR_S_WAIT && EE_WORD_VALID_I
    && EE_WORD_INDEX_I == 2'h0 && !CFG_WR_I |=> state_reg.wake_en == $past(EE_WORD_I[8]))
    else $error("wake enable not loaded");
  scale_track_a: assert property (DATA_SEL_O == 4'h8 [*2] |-> scale == 2'h2)
    else $error("scale mismatch");
  flag_set_a: assert property (WAKE_EVENT_I |=> state_reg.wake_flag)
    else $error("wake flag not set");
  flag_clear_a: assert property (CFG_WR_I && CFG_BE_I[1] && CFG_WDATA_I[15] && hit(CFG_ADDR_I, 8'h54)
    && !WAKE_EVENT_I |=> !state_reg.wake_flag) else $error("wake flag not cleared");
  reserved_zero_a: assert property (CFG_RVALID_O && $past(hit(CFG_ADDR_I, 8'h54))
    |-> CFG_RDATA_O[7:2] == 6'h00) else $error("reserved bits nonzero");
  revision_read_a: assert property (CFG_RD_I && CFG_ADDR_I == 8'h08
    |=> CFG_RVALID_O && CFG_RDATA_O == {8'h00, REVISION}) else $error("revision wrong");
  subsys_read_a: assert property (CFG_RD_I && hit(CFG_ADDR_I, 8'h2E)
    |=> CFG_RDATA_O == $past(state_reg.subsys)) else $error("subsystem wrong");
  resume_a: assert property (POWER_STATE_O == 2'b00 |-> TARGET_EN_O && MASTER_EN_O)
    else $error("no resume in D0");

  sleep_wake_c: cover property (POWER_STATE_O == 2'b11 ##[1:20] POWER_STATE_O == 2'b00);
  event_c: cover property (WAKE_O);
  set_clear_c: cover property (WAKE_EVENT_I && CFG_WR_I && CFG_WDATA_I[15]);
  init_c: cover property (state_reg.init == PMCR_S_WAIT ##1 state_reg.init == PMCR_S_READY);

endmodule

`default_nettype wire

// >>> tb/pmcr_host_model.sv
/*
  Host side of the configuration path: issues read and write cycles.
  Assumes the one-cycle strobe contract of pmcr_regs and one shared clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pmcr_map.svh"
module pmcr_host_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i,
  output var  logic        rd_o,
  output var  logic        wr_o,
  output var  logic [7:0]  addr_o,
  output var  logic [1:0]  be_o,
  output var  logic [15:0] wdata_o
);
  // ---------------------------------------------------------------------------
  // Cycle tasks, entered and left one step after a rising edge
  // ---------------------------------------------------------------------------
  initial begin
    rd_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 8'h00;
    be_o = 2'h0;
    wdata_o = 16'h0000;
  end
  // Write; reserved power-word bits leave as zero when the address is 8'h54, not at 8'h55
  task automatic wr(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
    wr_o = 1'b1;
    addr_o = a;
    be_o = b;
    wdata_o = (a == `PMCR_OFS_POWER_MGMT) ? (d & 16'hFF03) : d;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    addr_o = ~addr_o;   // Released address and data lines never keep their old value
    wdata_o = ~wdata_o;
    @(posedge clk_i);
    #1;
  endtask
  // Read; a missing answer leaves the data unknown so the caller sees it fail
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    int n;
    d = 16'hXXXX;
    n = 0;
    rd_o = 1'b1;
    addr_o = a;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    addr_o = ~addr_o;
    while (!rvalid_i && n < 4) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (rvalid_i) d = rdata_i;
    // Let an edge pass so a following cycle never re-raises a line in this step
    @(posedge clk_i);
    #1;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
/*
  Self-checking bench of pmcr_regs: ROM load, power states, select and scale,
  wake flag and output, identity reads. Assumes the host model beside it.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pmcr_map.svh"
module tb_top;
  logic        clk, rst_n, rd, wr, rvalid, ee_v, ee_done, wake_ev, wake, ten, men;
  logic [7:0]  addr;
  logic [1:0]  be, ee_idx, pst;
  logic [15:0] wdata, rdata, ee_w, d;
  logic [3:0]  dsel;
  int          fail_count, compares, cycles;
  localparam logic [7:0]  PM = `PMCR_OFS_POWER_MGMT;
  pmcr_regs #(.REVISION(8'h3C)) dut ( // Arbitrary revision value
    .REF_CLK_I(clk), .RSTN_I(rst_n), .CFG_RD_I(rd), .CFG_WR_I(wr), .CFG_ADDR_I(addr),
    .CFG_BE_I(be), .CFG_WDATA_I(wdata), .CFG_RDATA_O(rdata), .CFG_RVALID_O(rvalid),
    .EE_WORD_VALID_I(ee_v), .EE_WORD_INDEX_I(ee_idx), .EE_WORD_I(ee_w), .EE_DONE_I(ee_done),
    .WAKE_EVENT_I(wake_ev), .WAKE_O(wake), .TARGET_EN_O(ten), .MASTER_EN_O(men),
    .POWER_STATE_O(pst), .DATA_SEL_O(dsel));
  pmcr_host_model host (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .rd_o(rd),
    .wr_o(wr), .addr_o(addr), .be_o(be), .wdata_o(wdata));
  // ---------------------------------------------------------------------------
  // Clock, hang guard, shared helpers
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic ee(input logic [1:0] i, input logic [15:0] w);
    ee_v = 1'b1;
    ee_idx = i;
    ee_w = w;
    @(posedge clk);
    #1;
    ee_v = 1'b0;
    ee_w = ~w;
    // Gap cycle so back-to-back words never toggle the valid twice in one step
    @(posedge clk);
    #1;
  endtask
  task automatic pulse_wake();
    wake_ev = 1'b1;
    @(posedge clk);
    #1;
    wake_ev = 1'b0;
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    check("target", {15'h0000, ten}, 16'h0001);
    host.rd(PM, d);
    check("pm reset", d, `PMCR_PM_RESET);
  endtask
  // Later and unused ROM words must not disturb loaded fields
  task automatic t_rom();
    ee(2'h1, 16'hFFFF);
    ee(2'h0, 16'h0100);
    ee(2'h3, 16'h1234);
    ee_done = 1'b1;
    @(posedge clk);
    #1;
    ee_done = 1'b0;
    ee(2'h3, 16'hBEEF);
    host.rd(8'h2E, d);
    check("subsystem", d, 16'h1234);
    host.rd(PM, d);
    check("pm loaded", d, 16'h2100);
  endtask
  task automatic t_power();
    for (int s = 1; s < 4; s++) begin
      host.wr(PM, 2'b01, 16'(s));
      check("state", {14'h0000, pst}, 16'(s));
      check("gates", {14'h0000, ten, men}, 16'h0000);
      host.rd(PM, d);
      check("pm state", d, 16'h2100 | 16'(s));
    end
    host.wr(PM, 2'b01, 16'h0000);
    check("gates back", {14'h0000, ten, men}, 16'h0003);
  endtask
  // Boundary selects around the scale table; scale bits written as ones are ignored
  task automatic t_select();
    logic [3:0] sels [5] = '{4'h0, 4'h7, 4'h8, 4'h9, 4'hF};
    logic [1:0] sc;
    foreach (sels[k]) begin
      host.wr(PM, 2'b10, {3'b011, sels[k], 9'h100});
      sc = (sels[k] < 4'h8) ? 2'h1 : (sels[k] == 4'h8) ? 2'h2 : 2'h0;
      check("select", {12'h000, dsel}, {12'h000, sels[k]});
      host.rd(PM, d);
      check("scale", d, {1'b0, sc, sels[k], 9'h100});
    end
    host.wr(PM, 2'b10, 16'h0100);
  endtask
  task automatic t_wake();
    pulse_wake();
    check("wake on", {15'h0000, wake}, 16'h0001);
    host.rd(PM, d);
    check("flag set", d, 16'hA100);
    host.wr(PM, 2'b10, 16'h8100);
    host.rd(PM, d);
    check("flag clr", d, 16'h2100);
    host.wr(PM, 2'b10, 16'h0000);
    pulse_wake();
    check("wake off", {15'h0000, wake}, 16'h0000);
    host.rd(PM, d);
    check("flag dis", d, 16'hA000);
    wake_ev = 1'b1;
    fork
      host.wr(PM, 2'b10, 16'h8000);
      begin
        @(posedge clk);
        #1;
        wake_ev = 1'b0;
      end
    join
    host.rd(PM, d);
    check("set wins", d, 16'hA000);
  endtask
  // Identity registers refuse writes; unmapped reads give zero
  task automatic t_ids();
    host.wr(8'h08, 2'b11, 16'hFFFF);
    host.wr(8'h2E, 2'b11, 16'h0000);
    host.rd(8'h08, d);
    check("revision", d, 16'h003C);
    host.rd(8'h2E, d);
    check("subsys ro", d, 16'h1234);
    host.rd(8'h40, d);
    check("unmapped", d, 16'h0000);
  endtask
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    ee_v = 1'b0;
    ee_idx = 2'h0;
    ee_w = 16'h0000;
    ee_done = 1'b0;
    wake_ev = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_rom();
    t_power();
    t_select();
    t_wake();
    t_ids();
    summarize();
  end
endmodule
`default_nettype wire
